// ==== include/txfc_pkg.sv ====
// Contract
// - each packet still unacknowledged after the retries adds one to the failure counter.
// - the failure counter spans 0 to 0xffff and reads back as two bytes.
// - the failure counter is volatile and every reset clears it to zero.
// - command code 0x1b selects the failure counter.
// - once the byte limit is sent in a continuous stream, sending halts for a random backoff.
// - the byte limit is sixteen bits wide and zero disables the backoff.
// - the byte limit resets to 65535.
// - the backoff lasts a random 1 to slot setting plus one slots of 38 ms each.
// - command code 0x1a selects the byte limit, returned as two bytes.
package txfc_pkg;
  localparam logic [7:0]  CMD_TX_FAIL      = 8'h1b;
  localparam logic [7:0]  CMD_STREAM_LIM   = 8'h1a;
  localparam logic [11:0] ADDR_CMD         = 12'h000;
  localparam logic [11:0] ADDR_RESP        = 12'h004;
  localparam logic [11:0] ADDR_SLOTS       = 12'h008;
  localparam logic [11:0] ADDR_STATUS      = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_STAT    = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h014;
  localparam logic [15:0] FAIL_RESET       = 16'h0000;
  localparam logic [15:0] LIMIT_RESET      = 16'hffff;
  localparam logic [7:0]  SLOTS_RESET      = 8'h00;
  localparam logic [15:0] LFSR_SEED        = 16'hace1;
  localparam int          CMD_WRITE_BIT    = 8;
  localparam int          IRQ_FAIL_BIT     = 0;
  localparam int          IRQ_BACKOFF_BIT  = 1;
  localparam int          IRQ_DONE_BIT     = 2;
  localparam int          SLOT_MS          = 38;
  localparam int          CLK_MHZ          = 250;
  localparam int          SLOT_CYCLES      = SLOT_MS * 1000 * CLK_MHZ;
  typedef struct packed {
    logic       byte_sent;
    logic       stream_end;
    logic       retry_fail;
  } tx_evt_s;
endpackage

// ==== core/slot_timer.sv ====
`timescale 1ns/1ps
module slot_timer #(
  parameter int SLOT_LEN = txfc_pkg::SLOT_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        start,
  input  wire logic [8:0]  slots,
  // result
  output logic             busy,
  output logic             done
);
  import txfc_pkg::*;
  localparam int CW = $clog2(SLOT_LEN + 1);
  logic [CW-1:0] cyc_q, cyc_d;
  logic [8:0]    left_q, left_d;
  logic          busy_q, busy_d, done_q, done_d;
  logic          slot_end;
  assign slot_end = (cyc_q == CW'(SLOT_LEN - 1));
  always_comb begin
    cyc_d  = cyc_q;
    left_d = left_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start && !busy_q) begin
      busy_d = 1'b1;
      left_d = slots;
      cyc_d  = '0;
    end else if (busy_q) begin
      if (slot_end) begin
        cyc_d = '0;
        if (left_q == 9'h001) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end
        left_d = left_q - 9'h001;
      end else begin
        cyc_d = cyc_q + CW'(1);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q  <= '0;
      left_q <= 9'h000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cyc_q  <= cyc_d;
      left_q <= left_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end
  assign busy = busy_q;
  assign done = done_q;
endmodule

// ==== core/tx_fail_count_stream_limit.sv ====
`timescale 1ns/1ps
module tx_fail_count_stream_limit #(
  parameter int SLOT_LEN = txfc_pkg::SLOT_CYCLES
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // transmit path events
  input  wire txfc_pkg::tx_evt_s tx_evt,
  // transmit gate and interrupt
  output logic                  tx_halt,
  output logic                  irq
);
  import txfc_pkg::*;

  logic [15:0] fail_q, fail_d;
  logic [15:0] limit_q, limit_d;
  logic [7:0]  slots_q, slots_d;
  logic [15:0] resp_q, resp_d;
  logic [15:0] sent_q, sent_d;
  logic [15:0] lfsr_q, lfsr_d;
  logic [2:0]  ist_q, ist_d;
  logic [2:0]  imask_q, imask_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic        halt_q, halt_d;
  logic        irq_q, irq_d;
  logic        wr_acc, rd_acc, hit;
  logic        bo_start, bo_busy, bo_done, limit_hit;
  logic [8:0]  bo_slots;
  logic [2:0]  ev;
  logic        cmd_wr, cmd_bad, slots_wr, mask_wr, stat_wr;

  // access phase answered after one wait state
  assign wr_acc = psel && penable && pwrite && !pready_q;
  assign rd_acc = psel && penable && !pwrite && !pready_q;
  assign hit = (paddr == ADDR_CMD) || (paddr == ADDR_RESP) || (paddr == ADDR_SLOTS) ||
               (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_STAT) ||
               (paddr == ADDR_IRQ_MASK);

  // limit reached: halt on the byte that fills the limit
  assign limit_hit = tx_evt.byte_sent && (limit_q != 16'h0000) && !halt_q &&
                     (sent_q + 16'h0001 == limit_q);
  assign bo_start = limit_hit;
  // random count 1 .. setting+1
  assign bo_slots = 9'((lfsr_q[8:0] % ({1'b0, slots_q} + 9'h001)) + 9'h001);

  slot_timer #(
    .SLOT_LEN (SLOT_LEN)
  ) u_slot (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (bo_start),
    .slots   (bo_slots),
    .busy    (bo_busy),
    .done    (bo_done)
  );

  assign ev = {bo_done, limit_hit, tx_evt.retry_fail};

  // decoded register writes, taken once per access phase
  assign cmd_wr   = wr_acc && (paddr == ADDR_CMD) && (pstrb[1:0] != 2'b00);
  assign slots_wr = wr_acc && (paddr == ADDR_SLOTS) && pstrb[0];
  assign mask_wr  = wr_acc && (paddr == ADDR_IRQ_MASK) && pstrb[0];
  assign stat_wr  = wr_acc && (paddr == ADDR_IRQ_STAT) && pstrb[0];
  assign cmd_bad  = cmd_wr && (pwdata[7:0] != CMD_TX_FAIL) &&
                    (pwdata[7:0] != CMD_STREAM_LIM);

  // failure counter saturates instead of wrapping back to zero
  always_comb begin
    fail_d = fail_q;
    if (tx_evt.retry_fail && (fail_q != 16'hffff)) begin
      fail_d = fail_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_q <= FAIL_RESET;
    end else begin
      fail_q <= fail_d;
    end
  end

  // command decode: the response is a snapshot taken at the command write
  always_comb begin
    limit_d = limit_q;
    resp_d  = resp_q;
    if (cmd_wr) begin
      if (pwdata[7:0] == CMD_TX_FAIL) begin
        resp_d = fail_q;
      end else if (pwdata[7:0] == CMD_STREAM_LIM) begin
        if (pwdata[CMD_WRITE_BIT] && (pstrb[3:2] == 2'b11)) begin
          limit_d = pwdata[31:16];
        end
        resp_d = pwdata[CMD_WRITE_BIT] ? pwdata[31:16] : limit_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_q <= LIMIT_RESET;
      resp_q  <= 16'h0000;
    end else begin
      limit_q <= limit_d;
      resp_q  <= resp_d;
    end
  end

  // backoff slot setting and interrupt mask
  always_comb begin
    slots_d = slots_q;
    imask_d = imask_q;
    if (slots_wr) begin
      slots_d = pwdata[7:0];
    end
    if (mask_wr) begin
      imask_d = pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slots_q <= SLOTS_RESET;
      imask_q <= 3'b000;
    end else begin
      slots_q <= slots_d;
      imask_q <= imask_d;
    end
  end

  // stream byte count, transmit gate and the free-running random source
  always_comb begin
    sent_d = sent_q;
    halt_d = halt_q;
    lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    if (limit_hit) begin
      halt_d = 1'b1;
      sent_d = 16'h0000;
    end else if (bo_done || tx_evt.stream_end) begin
      sent_d = 16'h0000;
    end else if (tx_evt.byte_sent && !halt_q) begin
      sent_d = sent_q + 16'h0001;
    end
    if (bo_done) begin
      halt_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_q <= 16'h0000;
      halt_q <= 1'b0;
      lfsr_q <= LFSR_SEED;
    end else begin
      sent_q <= sent_d;
      halt_q <= halt_d;
      lfsr_q <= lfsr_d;
    end
  end

  // sticky status bits: an event in the cycle of a clear wins
  for (genvar i = 0; i < 3; i++) begin : g_ist
    always_comb begin
      ist_d[i] = ist_q[i];
      if (stat_wr && pwdata[i]) begin
        ist_d[i] = 1'b0;
      end
      if (ev[i]) begin
        ist_d[i] = 1'b1;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ist_q[i] <= 1'b0;
      end else begin
        ist_q[i] <= ist_d[i];
      end
    end
  end

  // level interrupt from the next status, so it tracks the bits without lag
  always_comb begin
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // apb answer: one wait state, read data held until the next read
  always_comb begin
    pready_d  = psel && penable && !pready_q;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (wr_acc && (!hit || cmd_bad)) begin
      pslverr_d = 1'b1;
    end
    if (rd_acc) begin
      if (paddr == ADDR_RESP) begin
        prdata_d = {16'h0000, resp_q};
      end else if (paddr == ADDR_SLOTS) begin
        prdata_d = {24'h000000, slots_q};
      end else if (paddr == ADDR_STATUS) begin
        prdata_d = {sent_q, 14'h0000, bo_busy, halt_q};
      end else if (paddr == ADDR_IRQ_STAT) begin
        prdata_d = {29'h0, ist_q};
      end else if (paddr == ADDR_IRQ_MASK) begin
        prdata_d = {29'h0, imask_q};
      end else if (paddr == ADDR_CMD) begin
        prdata_d = 32'h00000000;
      end else begin
        prdata_d  = 32'h00000000;
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign tx_halt = halt_q;
  assign irq     = irq_q;
endmodule

// ==== sim/txfc_properties.sv ====
`timescale 1ns/1ps
module txfc_checker import txfc_pkg::*; #(parameter int SLOT_LEN = 10) (
  // clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // apb
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [3:0]    pstrb,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // transmit side
  input wire txfc_pkg::tx_evt_s tx_evt,
  input wire logic          tx_halt,
  input wire logic          irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] halt_q;
  logic [31:0] halt_d;
  always_comb halt_d = tx_halt ? halt_q + 1 : '0;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) halt_q <= '0;
    else halt_q <= halt_d;
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait state");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_cause; pready |-> $past(psel && penable); endproperty
  a_cause: assert property (p_cause) else $error("ready without access phase");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_halt_cause; $rose(tx_halt) |-> $past(tx_evt.byte_sent); endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without byte");
  property p_halt_min; $rose(tx_halt) |-> tx_halt [*8]; endproperty
  a_halt_min: assert property (p_halt_min) else $error("backoff too short");
  property p_halt_max; halt_q <= 256 * SLOT_LEN + 8; endproperty
  a_halt_max: assert property (p_halt_max) else $error("backoff too long");
  property p_rst; disable iff (1'b0) !presetn |-> !tx_halt && !irq && !pready; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
endmodule
bind tx_fail_count_stream_limit txfc_checker #(.SLOT_LEN(SLOT_LEN)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_evt(tx_evt), .tx_halt(tx_halt), .irq(irq));

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic        pclk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
  end
  // a lost answer returns unknowns so the caller's compare fails
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic e);
    int n;
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1;
    rd = 'x;
    e = 'x;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready === 1'b1) {rd, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
endmodule

// ==== sim/tx_fail_count_stream_limit_bench.sv ====
`timescale 1ns/1ps
module tx_fail_count_stream_limit_bench;
  import txfc_pkg::*;
  localparam int SL = 10;
  logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, tx_halt, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  tx_evt_s     ev = '0;
  int err_count = 0, cmp_count = 0;
  always #2 pclk = ~pclk;
  tx_fail_count_stream_limit #(.SLOT_LEN(SL)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_evt(ev),
    .tx_halt(tx_halt), .irq(irq));
  host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task end_sim;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task cmd(logic [7:0] c, logic w, logic [15:0] v, logic [31:0] x, logic er);
    logic [31:0] rd;
    logic e;
    i_host.xfer(1, ADDR_CMD, {v, 7'h00, w, c}, rd, e);
    chk("cmd error", {31'h0, er}, {31'h0, e});
    if (!er) begin
      i_host.xfer(0, ADDR_RESP, '0, rd, e);
      chk("response", x, rd);
    end
  endtask
  task evt(tx_evt_s v, int n);
    repeat (n) @(posedge pclk) ev <= v;
    @(posedge pclk) ev <= '0;
    #1;
  endtask
  task wback;
    int n;
    n = 0;
    while (tx_halt === 1'b1 && n < 4 * SL) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("backoff length", 1, {31'h0, n >= SL && tx_halt === 1'b0});
  endtask
  task t_defaults;
    logic [31:0] rd;
    logic e;
    cmd(CMD_STREAM_LIM, 0, 0, 32'hffff, 0);
    cmd(CMD_TX_FAIL, 0, 0, 0, 0);
    cmd(8'h55, 0, 0, 0, 1);
    i_host.xfer(0, 12'hff0, '0, rd, e);
    chk("unmapped", 1, {31'h0, e});
  endtask
  task t_fail;
    logic [31:0] rd;
    logic e;
    i_host.xfer(1, ADDR_IRQ_MASK, 32'h1, rd, e);
    evt(tx_evt_s'(3'b001), 3);
    @(posedge pclk) #1;
    chk("irq set", 1, {31'h0, irq});
    cmd(CMD_TX_FAIL, 0, 0, 3, 0);
    i_host.xfer(1, ADDR_IRQ_STAT, 32'h1, rd, e);
    @(posedge pclk) #1;
    chk("irq cleared", 0, {31'h0, irq});
  endtask
  task t_stream;
    logic [31:0] rd;
    logic e;
    cmd(CMD_STREAM_LIM, 1, 3, 3, 0);
    i_host.xfer(1, ADDR_SLOTS, '0, rd, e);
    evt(tx_evt_s'(3'b100), 2);
    evt(tx_evt_s'(3'b010), 1);
    evt(tx_evt_s'(3'b100), 2);
    chk("no halt after end", 0, {31'h0, tx_halt});
    evt(tx_evt_s'(3'b100), 1);
    chk("halt at limit", 1, {31'h0, tx_halt});
    wback;
    evt(tx_evt_s'(3'b100), 3);
    chk("halt after restart", 1, {31'h0, tx_halt});
    wback;
  endtask
  task t_nolimit;
    cmd(CMD_STREAM_LIM, 1, 0, 0, 0);
    evt(tx_evt_s'(3'b100), 5);
    @(posedge pclk) #1;
    chk("no halt when off", 0, {31'h0, tx_halt});
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_defaults;
    t_fail;
    t_stream;
    t_nolimit;
    end_sim;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    end_sim;
  end
endmodule
